//--- ppd_pkg.sv
// Package for the peak power hysteresis detector.
// Assumes one 10 MHz clock, standing in for the sample clock divided by 8.
package ppd_pkg;

  // ==========================================================================
  // Register offsets (byte-wide registers, one per address).
  // ==========================================================================
  localparam logic [7:0] ADDR_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_HU_THR = 8'h07;
  localparam logic [7:0] ADDR_HL_THR = 8'h08;
  localparam logic [7:0] ADDR_LU_THR = 8'h09;
  localparam logic [7:0] ADDR_LL_THR = 8'h0a;
  localparam logic [7:0] ADDR_HOLD_LO = 8'h0b;
  localparam logic [7:0] ADDR_HOLD_HI = 8'h0c;
  localparam logic [7:0] ADDR_IIR_SEL = 8'h0d;
  localparam logic [7:0] ADDR_TCONST = 8'h0e;
  localparam logic [7:0] ADDR_F0U_LO = 8'h0f;
  localparam logic [7:0] ADDR_F0U_HI = 8'h10;
  localparam logic [7:0] ADDR_F0L_LO = 8'h11;
  localparam logic [7:0] ADDR_F0L_HI = 8'h12;
  localparam logic [7:0] ADDR_BLK_LO = 8'h01;
  localparam logic [7:0] ADDR_BLK_MID = 8'h02;
  localparam logic [7:0] ADDR_BLK_TOP = 8'h03;
  localparam logic [7:0] ADDR_FLAGS = 8'h30;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h31;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h32;
  localparam logic [7:0] ADDR_TICK = 8'h33;

  // ==========================================================================
  // Reset values, field positions and counts.
  // ==========================================================================
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [16:0] RST_BLK_LEN = 17'h00000;
  localparam int IIR_SEL_BIT = 0;
  localparam int TCONST_W = 4;
  localparam int GROUP_LEN = 8;
  localparam int FULL_SCALE = 256;
  localparam logic [15:0] CROSS_MAX = 16'h8000;
  localparam int EVT_HI_SET = 0;
  localparam int EVT_HI_CLR = 1;
  localparam int EVT_LO_SET = 2;
  localparam int EVT_LO_CLR = 3;
  localparam int EVT_PERIOD = 4;

  // One hysteresis pair: thresholds and flag_hold_count.
  typedef struct packed {
    logic [7:0] upper;
    logic [7:0] lower;
    logic [15:0] hold;
  } ppd_hyst_cfg_s;

  // Three-level filter input code.
  typedef enum logic [1:0] {
    PPD_LVL_ZERO = 2'b00,
    PPD_LVL_POS = 2'b01,
    PPD_LVL_NEG = 2'b11
  } ppd_level_e;

endpackage

//--- ppd_hyst.sv
// One hysteresis flag with flag_hold_count-count release.
// Assumes peak_vld pulses once per finished block peak, clock is fs/8.
`timescale 1ns/10ps
module ppd_hyst (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic peak_vld,
  input wire logic [8:0] peak,
  input wire ppd_pkg::ppd_hyst_cfg_s cfg,
  output logic flag,
  output logic set_evt,
  output logic clr_evt
);
  import ppd_pkg::*;

  typedef struct packed {
    logic flag;
    logic below;
    logic [15:0] cnt;
    logic set_evt;
    logic clr_evt;
  } ppd_hyst_st_s;

  ppd_hyst_st_s st_q;
  ppd_hyst_st_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.set_evt = 1'b0;
    st_d.clr_evt = 1'b0;
    if (!enable) begin
      st_d.flag = 1'b0;
      st_d.below = 1'b0;
      st_d.cnt = 16'h0000;
    end else begin
      if (peak_vld) begin
        if (peak > {1'b0, cfg.upper}) begin
          st_d.set_evt = !st_q.flag;
          st_d.flag = 1'b1;
        end
        // A peak not below the lower threshold restarts the wait.
        st_d.below = peak < {1'b0, cfg.lower};
        if (!(peak < {1'b0, cfg.lower}))
          st_d.cnt = 16'h0000;
      end
      if (st_q.flag && st_q.below && !(peak_vld && !st_d.below)) begin
        if (st_q.cnt >= cfg.hold) begin
          // A set in the same cycle wins over the release.
          st_d.flag = peak_vld && (peak > {1'b0, cfg.upper});
          st_d.clr_evt = !st_d.flag;
          st_d.cnt = 16'h0000;
        end else begin
          st_d.cnt = st_q.cnt + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign flag = st_q.flag;
  assign set_evt = st_q.set_evt;
  assign clr_evt = st_q.clr_evt;
endmodule

//--- ppd_top.sv
// Peak power hysteresis detector: registers, block peak, flags, filter input.
// Assumes byte-wide register port on ref_clk; samples arrive in ref_clk domain.
//
// Notes on behaviour
// - Four 8-bit thresholds scale linearly 0..255, 256 being full peak.
// - A block peak above an upper threshold sets that pair's flag.
// - While enabled, a flag clears only after the peak stays below its lower threshold unbroken for the flag_hold_count.
// - The flag_hold_count is a 16-bit count over two bytes in fs/8 cycles.
// - With select 0 the filter input comes from the high pair only.
// - With select 1 both pairs form a three-level filter input of -1, 0, +1.
// - A 4-bit field N sets the crossing period to 2 to the N fs/8 cycles.
// - The crossing period never exceeds 32768 fs/8 cycles.
// - The detector runs only while its enable bit is 1.
// - Each sample is the max of 8 converter samples; the block peak spans a set count.
// - Filter thresholds are 16-bit signed 2.14 values, 4000h being 100 percent.
`timescale 1ns/10ps
module ppd_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic samp_vld,
  input wire logic [7:0] samp_mag,
  output logic [7:0] reg_rdata,
  output logic high_flag,
  output logic low_flag,
  output logic [1:0] iir_in,
  output logic iir_in_vld,
  output logic period_tick,
  output logic [15:0] filt_upper_thr,
  output logic [15:0] filt_lower_thr,
  output logic irq
);
  import ppd_pkg::*;

  // ==========================================================================
  // State.
  // ==========================================================================
  // Besides the threshold, flag_hold_count and filter bytes the map holds: 0x00 the
  // enable in bit 0, 0x01 to 0x03 the 17-bit block length, 0x30 the two
  // flags (bit 0 high pair), 0x31 the sticky event status, cleared by
  // writing ones, 0x32 its mask and 0x33 the running block maximum for
  // debug. Status bits from bit 0 up: high set, high clear, low set, low
  // clear and period tick.

  typedef struct packed {
    logic enable;
    logic [7:0] hu;
    logic [7:0] hl;
    logic [7:0] lu;
    logic [7:0] ll;
    logic [15:0] hold;
    logic iir_sel;
    logic [3:0] tconst;
    logic [15:0] f0u;
    logic [15:0] f0l;
    logic [16:0] blk_len;
    logic [7:0] grp_max;
    logic [2:0] grp_cnt;
    logic [8:0] blk_max;
    logic [16:0] blk_cnt;
    logic [8:0] peak;
    logic peak_vld;
    logic [15:0] per_cnt;
    logic tick;
    logic [1:0] lvl;
    logic lvl_vld;
    logic [4:0] stat;
    logic [4:0] mask;
    logic irq;
    logic [7:0] rdata;
  } ppd_top_st_s;

  ppd_top_st_s st_q;
  ppd_top_st_s st_d;

  logic hi_flag;
  logic lo_flag;
  logic hi_set;
  logic hi_clr;
  logic lo_set;
  logic lo_clr;
  ppd_hyst_cfg_s hi_cfg;
  ppd_hyst_cfg_s lo_cfg;

  // Period length from the time constant, held at the ceiling.
  // Two to the fifteen already meets the ceiling; the clamp guards wider N.
  function automatic logic [15:0] period_len(input logic [3:0] n);
    logic [16:0] p;
    p = 17'h00001 << n;
    if (p > {1'b0, CROSS_MAX})
      p = {1'b0, CROSS_MAX};
    return p[15:0];
  endfunction

  // Combine low and high bytes of a split field.
  function automatic logic [15:0] join16(input logic [7:0] hi,
                                        input logic [7:0] lo);
    return {hi, lo};
  endfunction

  // ==========================================================================
  // Hysteresis pairs.
  // ==========================================================================
  // Both pairs use the one flag_hold_count value; each pair keeps its own count.
  assign hi_cfg = '{upper: st_q.hu, lower: st_q.hl, hold: st_q.hold};
  assign lo_cfg = '{upper: st_q.lu, lower: st_q.ll, hold: st_q.hold};

  ppd_hyst u_high (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(st_q.enable),
    .peak_vld(st_q.peak_vld),
    .peak(st_q.peak),
    .cfg(hi_cfg),
    .flag(hi_flag),
    .set_evt(hi_set),
    .clr_evt(hi_clr)
  );

  ppd_hyst u_low (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(st_q.enable),
    .peak_vld(st_q.peak_vld),
    .peak(st_q.peak),
    .cfg(lo_cfg),
    .flag(lo_flag),
    .set_evt(lo_set),
    .clr_evt(lo_clr)
  );

  // ==========================================================================
  // Next state.
  // ==========================================================================
  always_comb begin
    logic [4:0] evt;
    logic [7:0] gmax;
    logic [8:0] bmax;
    evt = 5'h00;
    evt[EVT_HI_SET] = hi_set;
    evt[EVT_HI_CLR] = hi_clr;
    evt[EVT_LO_SET] = lo_set;
    evt[EVT_LO_CLR] = lo_clr;
    evt[EVT_PERIOD] = st_q.tick;
    gmax = 8'h00;
    bmax = 9'h000;
    st_d = st_q;
    st_d.peak_vld = 1'b0;
    st_d.tick = 1'b0;
    st_d.lvl_vld = 1'b0;
    // Read data stand for one cycle only and read as zero otherwise.
    st_d.rdata = RST_BYTE;

    // ========================================================================
    // Register writes.
    if (reg_wr) begin
      case (reg_addr)
        ADDR_ENABLE: st_d.enable = reg_wdata[0];
        ADDR_HU_THR: st_d.hu = reg_wdata;
        ADDR_HL_THR: st_d.hl = reg_wdata;
        ADDR_LU_THR: st_d.lu = reg_wdata;
        ADDR_LL_THR: st_d.ll = reg_wdata;
        ADDR_HOLD_LO: st_d.hold[7:0] = reg_wdata;
        ADDR_HOLD_HI: st_d.hold[15:8] = reg_wdata;
        // Upper bits of the next two bytes are dropped; software keeps 0.
        ADDR_IIR_SEL: st_d.iir_sel = reg_wdata[IIR_SEL_BIT];
        ADDR_TCONST: st_d.tconst = reg_wdata[TCONST_W-1:0];
        ADDR_F0U_LO: st_d.f0u[7:0] = reg_wdata;
        ADDR_F0U_HI: st_d.f0u[15:8] = reg_wdata;
        ADDR_F0L_LO: st_d.f0l[7:0] = reg_wdata;
        ADDR_F0L_HI: st_d.f0l[15:8] = reg_wdata;
        ADDR_BLK_LO: st_d.blk_len[7:0] = reg_wdata;
        ADDR_BLK_MID: st_d.blk_len[15:8] = reg_wdata;
        ADDR_BLK_TOP: st_d.blk_len[16] = reg_wdata[0];
        ADDR_IRQ_MASK: st_d.mask = reg_wdata[4:0];
        default: ;
      endcase
    end

    // ========================================================================
    // Register reads, answered one cycle later.
    if (reg_rd) begin
      case (reg_addr)
        ADDR_ENABLE: st_d.rdata = {7'h00, st_q.enable};
        ADDR_HU_THR: st_d.rdata = st_q.hu;
        ADDR_HL_THR: st_d.rdata = st_q.hl;
        ADDR_LU_THR: st_d.rdata = st_q.lu;
        ADDR_LL_THR: st_d.rdata = st_q.ll;
        ADDR_HOLD_LO: st_d.rdata = st_q.hold[7:0];
        ADDR_HOLD_HI: st_d.rdata = st_q.hold[15:8];
        ADDR_IIR_SEL: st_d.rdata = {7'h00, st_q.iir_sel};
        ADDR_TCONST: st_d.rdata = {4'h0, st_q.tconst};
        ADDR_F0U_LO: st_d.rdata = st_q.f0u[7:0];
        ADDR_F0U_HI: st_d.rdata = st_q.f0u[15:8];
        ADDR_F0L_LO: st_d.rdata = st_q.f0l[7:0];
        ADDR_F0L_HI: st_d.rdata = st_q.f0l[15:8];
        ADDR_BLK_LO: st_d.rdata = st_q.blk_len[7:0];
        ADDR_BLK_MID: st_d.rdata = st_q.blk_len[15:8];
        ADDR_BLK_TOP: st_d.rdata = {7'h00, st_q.blk_len[16]};
        ADDR_FLAGS: st_d.rdata = {6'h00, lo_flag, hi_flag};
        ADDR_IRQ_STAT: st_d.rdata = {3'h0, st_q.stat};
        ADDR_IRQ_MASK: st_d.rdata = {3'h0, st_q.mask};
        // Debug view of the running block maximum, low eight bits only.
        ADDR_TICK: st_d.rdata = st_q.blk_max[7:0];
        default: st_d.rdata = RST_BYTE;
      endcase
    end

    // ========================================================================
    // Sticky status: a new event wins over a write-one clear.
    if (reg_wr && reg_addr == ADDR_IRQ_STAT)
      st_d.stat = st_q.stat & ~reg_wdata[4:0];
    st_d.stat = st_d.stat | evt;
    // Built from the next status and mask, so irq follows a write at once.
    st_d.irq = |(st_d.stat & st_d.mask);

    // ========================================================================
    // Block peak, period and filter input, all idle while disabled.
    if (!st_q.enable) begin
      st_d.grp_cnt = 3'h0;
      st_d.grp_max = 8'h00;
      st_d.blk_cnt = RST_BLK_LEN;
      st_d.blk_max = 9'h000;
      st_d.per_cnt = 16'h0000;
      // A stale +1 must not linger on the filter input while off.
      st_d.lvl = PPD_LVL_ZERO;
    end else begin
      // ======================================================================
      // Group of eight samples gives one reduced sample.
      // A block length of zero or one makes every group a block of its own.
      if (samp_vld) begin
        gmax = (st_q.grp_cnt == 3'h0 || samp_mag > st_q.grp_max) ?
               samp_mag : st_q.grp_max;
        st_d.grp_max = gmax;
        st_d.grp_cnt = st_q.grp_cnt + 3'h1;
        if (st_q.grp_cnt == 3'(GROUP_LEN - 1)) begin
          bmax = (st_q.blk_cnt == RST_BLK_LEN ||
                  {1'b0, gmax} > st_q.blk_max) ?
                 {1'b0, gmax} : st_q.blk_max;
          if (st_q.blk_cnt + 17'h00001 >= st_q.blk_len) begin
            st_d.peak = bmax;
            st_d.peak_vld = 1'b1;
            st_d.blk_cnt = RST_BLK_LEN;
            st_d.blk_max = 9'h000;
          end else begin
            st_d.blk_max = bmax;
            st_d.blk_cnt = st_q.blk_cnt + 17'h00001;
          end
        end
      end

      // ======================================================================
      // Crossing period counter in fs/8 cycles.
      // It runs while enabled whether or not samples arrive.
      if (st_q.per_cnt + 16'h0001 >= period_len(st_q.tconst)) begin
        st_d.per_cnt = 16'h0000;
        st_d.tick = 1'b1;
      end else begin
        st_d.per_cnt = st_q.per_cnt + 16'h0001;
      end

      // ======================================================================
      // Filter input from the comparator flags.
      st_d.lvl_vld = 1'b1;
      if (!st_q.iir_sel)
        st_d.lvl = hi_flag ? PPD_LVL_POS : PPD_LVL_ZERO;
      else if (hi_flag)
        st_d.lvl = PPD_LVL_POS;
      else if (!lo_flag)
        st_d.lvl = PPD_LVL_NEG;
      else
        st_d.lvl = PPD_LVL_ZERO;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // ==========================================================================
  // Outputs, all from flip-flops.
  // ==========================================================================
  assign reg_rdata = st_q.rdata;
  // The flags come straight from the registers inside each pair.
  assign high_flag = hi_flag;
  assign low_flag = lo_flag;
  assign iir_in = st_q.lvl;
  assign iir_in_vld = st_q.lvl_vld;
  assign period_tick = st_q.tick;
  assign filt_upper_thr = join16(st_q.f0u[15:8], st_q.f0u[7:0]);
  assign filt_lower_thr = join16(st_q.f0l[15:8], st_q.f0l[7:0]);
  assign irq = st_q.irq;
endmodule

//--- ppd_monitor.sv
// Checker for the peak power detector top level.
// Assumes it is bound to ppd_top; one clock, synchronous reset.
`timescale 1ns/10ps
module ppd_monitor
  import ppd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic samp_vld,
  input wire logic [7:0] samp_mag,
  input wire logic [7:0] reg_rdata,
  input wire logic high_flag,
  input wire logic low_flag,
  input wire logic [1:0] iir_in,
  input wire logic iir_in_vld,
  input wire logic period_tick,
  input wire logic [15:0] filt_upper_thr,
  input wire logic [15:0] filt_lower_thr,
  input wire logic irq
);
  // =========
  // Properties.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_rd; reg_rdata != 8'h00 |-> $past(reg_rd); endproperty
  a_rd: assert property (p_rd) else $error("data outside read slot");
  property p_fu;
    reg_wr && reg_addr == ADDR_F0U_HI |->
      ##1 filt_upper_thr[15:8] == $past(reg_wdata);
  endproperty
  a_fu: assert property (p_fu) else $error("upper high byte lost");
  property p_fl;
    reg_wr && reg_addr == ADDR_F0L_LO |->
      ##1 filt_lower_thr[7:0] == $past(reg_wdata);
  endproperty
  a_fl: assert property (p_fl) else $error("lower low byte lost");
  property p_off;
    reg_wr && reg_addr == ADDR_ENABLE && !reg_wdata[0] |->
      ##2 !high_flag && !low_flag;
  endproperty
  a_off: assert property (p_off) else $error("flag while off");
  property p_voff;
    reg_wr && reg_addr == ADDR_ENABLE && !reg_wdata[0] |-> ##2 !iir_in_vld;
  endproperty
  a_voff: assert property (p_voff) else $error("input valid when off");
  property p_code; iir_in != 2'b10; endproperty
  a_code: assert property (p_code) else $error("illegal level code");
  property p_pos;
    iir_in == PPD_LVL_POS |-> high_flag || $past(high_flag);
  endproperty
  a_pos: assert property (p_pos) else $error("plus without flag");
  property p_rise;
    $rose(high_flag) |-> $past(samp_vld, 2) || $past(samp_vld, 3);
  endproperty
  a_rise: assert property (p_rise) else $error("flag without peak");
  property p_mask;
    reg_wr && reg_addr == ADDR_IRQ_MASK && reg_wdata == 8'h00 |-> ##1 !irq;
  endproperty
  a_mask: assert property (p_mask) else $error("masked irq high");
endmodule

bind ppd_top ppd_monitor u_mon (.ref_clk(ref_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .samp_vld(samp_vld), .samp_mag(samp_mag),
  .reg_rdata(reg_rdata), .high_flag(high_flag), .low_flag(low_flag),
  .iir_in(iir_in), .iir_in_vld(iir_in_vld), .period_tick(period_tick),
  .filt_upper_thr(filt_upper_thr), .filt_lower_thr(filt_lower_thr),
  .irq(irq));

//--- ppd_tb.sv
// Self-checking bench for the peak power detector top level.
// Assumes ppd_pkg and ppd_top compiled first; 10 MHz clock.
`timescale 1ns/10ps
module tb;
  import ppd_pkg::*;
  logic ref_clk, rst, reg_wr, reg_rd, samp_vld;
  logic [7:0] reg_addr, reg_wdata, samp_mag, reg_rdata;
  logic high_flag, low_flag, iir_in_vld, period_tick, irq;
  logic [1:0] iir_in;
  logic [15:0] filt_upper_thr, filt_lower_thr, rv;
  int err_total = 0;
  int checked = 0;
  int n;
  ppd_top u_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .samp_vld(samp_vld), .samp_mag(samp_mag), .reg_rdata(reg_rdata),
    .high_flag(high_flag), .low_flag(low_flag), .iir_in(iir_in),
    .iir_in_vld(iir_in_vld), .period_tick(period_tick),
    .filt_upper_thr(filt_upper_thr), .filt_lower_thr(filt_lower_thr),
    .irq(irq));
  // =========
  // Clock and tasks.
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic stop_test();
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rv = 16'(reg_rdata);
  endtask
  // One group of eight samples; the largest sits in the middle on purpose.
  task automatic feed(input logic [7:0] base, input logic [7:0] pk);
    for (int i = 0; i < GROUP_LEN; i++) begin
      @(posedge ref_clk);
      samp_vld <= 1'b1;
      samp_mag <= (i == 3) ? pk : base;
    end
  endtask
  task automatic idle(input int c);
    @(posedge ref_clk);
    samp_vld <= 1'b0;
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task automatic tick_gap();
    n = 0;
    do begin @(posedge ref_clk); #1; n++; end
    while (period_tick !== 1'b1 && n < 40000);
    n = 0;
    do begin @(posedge ref_clk); #1; n++; end
    while (period_tick !== 1'b1 && n < 40000);
  endtask
  function automatic logic [7:0] dval(input int a);
    return (a == 13) ? 8'h01 : (a == 14) ? 8'h0f : 8'(a * 17);
  endfunction
  // =========
  // Tests.
  initial begin
    #9000000;
    err_total++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    stop_test();
  end
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    samp_vld = 1'b0;
    samp_mag = 8'h00;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    for (int a = 7; a <= 18; a++) begin
      rd(8'(a));
      chk(rv, 16'h0000);
      wr(8'(a), dval(a));
    end
    for (int a = 7; a <= 18; a++) begin
      rd(8'(a));
      chk(rv, 16'(dval(a)));
    end
    chk(filt_upper_thr, 16'h10ff);
    chk(filt_lower_thr, 16'h3221);
    wr(8'h20, 8'hff);
    rd(8'h20);
    chk(rv, 16'h0000);
    wr(ADDR_HU_THR, 8'h64);
    wr(ADDR_HL_THR, 8'h32);
    wr(ADDR_LU_THR, 8'hc8);
    wr(ADDR_LL_THR, 8'h14);
    wr(ADDR_HOLD_LO, 8'h08);
    wr(ADDR_HOLD_HI, 8'h00);
    wr(ADDR_IIR_SEL, 8'h00);
    wr(ADDR_TCONST, 8'h02);
    wr(ADDR_IRQ_MASK, 8'h0f);
    wr(ADDR_ENABLE, 8'h01);
    feed(8'h0a, 8'h78);
    idle(3);
    chk(16'(high_flag), 16'h0001);
    chk(16'(low_flag), 16'h0000);
    chk(16'(iir_in), 16'(PPD_LVL_POS));
    chk(16'(iir_in_vld), 16'h0001);
    feed(8'h28, 8'h28);
    feed(8'h3c, 8'h3c);
    idle(5);
    chk(16'(high_flag), 16'h0001);
    feed(8'h28, 8'h28);
    idle(4);
    chk(16'(high_flag), 16'h0001);
    idle(9);
    chk(16'(high_flag), 16'h0000);
    chk(16'(iir_in), 16'(PPD_LVL_ZERO));
    wr(ADDR_HOLD_LO, 8'h00);
    wr(ADDR_IIR_SEL, 8'h01);
    idle(2);
    chk(16'(iir_in), 16'(PPD_LVL_NEG));
    feed(8'h0a, 8'hd2);
    idle(3);
    chk(16'({high_flag, low_flag}), 16'h0003);
    chk(16'(iir_in), 16'(PPD_LVL_POS));
    rd(ADDR_FLAGS);
    chk(rv, 16'h0003);
    rd(ADDR_IRQ_STAT);
    chk(rv & 16'h000f, 16'h0007);
    chk(16'(irq), 16'h0001);
    wr(ADDR_IRQ_MASK, 8'h00);
    idle(2);
    chk(16'(irq), 16'h0000);
    wr(ADDR_IRQ_MASK, 8'h0f);
    idle(2);
    chk(16'(irq), 16'h0001);
    wr(ADDR_IRQ_STAT, 8'h0f);
    rd(ADDR_IRQ_STAT);
    chk(rv & 16'h000f, 16'h0000);
    chk(16'(irq), 16'h0000);
    tick_gap();
    chk(16'(n), 16'h0004);
    wr(ADDR_TCONST, 8'h0f);
    tick_gap();
    chk(16'(n), 16'h8000);
    wr(ADDR_ENABLE, 8'h00);
    idle(2);
    chk(16'({high_flag, low_flag, iir_in_vld}), 16'h0000);
    // Two groups per block: the peak of the first only counts at the end.
    wr(ADDR_BLK_LO, 8'h02);
    wr(ADDR_ENABLE, 8'h01);
    feed(8'h0a, 8'h70);
    idle(3);
    chk(16'(high_flag), 16'h0000);
    feed(8'h0a, 8'h0a);
    idle(3);
    chk(16'(high_flag), 16'h0001);
    stop_test();
  end
endmodule
